/* core/msj_pkg.sv */
// Shared constants and types for the memory-operand instruction executor.
package msj_pkg;

  // ----------------------------------------------------------------------
  // Word and field layout
  // ----------------------------------------------------------------------
  localparam int WORD_W = 12;
  localparam int OPC_HI = 11;
  localparam int OPC_LO = 9;
  localparam int IND_BIT = 8;
  localparam int PAGE_BIT = 7;
  localparam int OFS_HI = 6;
  localparam int PAGE_HI = 11;
  localparam int PAGE_LO = 7;

  // ----------------------------------------------------------------------
  // Opcodes and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] OPC_INC_SKIP = 3'h2;
  localparam logic [2:0] OPC_STORE_CLEAR = 3'h3;
  localparam logic [2:0] OPC_CALL = 3'h4;
  localparam logic [2:0] OPC_JUMP = 3'h5;
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [11:0] RES_RESET = 12'h000;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic [11:0] WORD_ZERO = 12'h000;
  localparam logic [11:0] WORD_ONE = 12'h001;

  typedef enum logic [2:0] {
    MSJ_IDLE = 3'b000,
    MSJ_DEFER = 3'b001,
    MSJ_READ = 3'b011,
    MSJ_WRITE = 3'b010,
    MSJ_DONE = 3'b110
  } msj_state_type;

endpackage

/* core/msj_mem.sv */
// Small word memory with registered read data, used as main memory.
module msj_mem (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [11:0] addr,
  input wire logic [11:0] wdata,
  output logic [11:0] rdata
);

  logic [11:0] mem_q [0:4095];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
    rdata <= mem_q[addr];
  end

endmodule

/* core/msj_exec.sv */
// Execute logic for store-and-clear, jump, increment-skip and call instructions.
//
// Contract
// - Opcode 3 writes the result register into the word at the effective address.
// - After that write, the result register becomes zero.
// - Store-and-clear leaves the carry flag alone.
// - Opcode 5 loads the effective address into the instruction pointer.
// - Jump changes neither the result register nor the carry flag.
// - Opcode 2 reads the word at the effective address and adds one modulo 4096.
// - If the incremented word is zero the following instruction is skipped.
// - The incremented word is written back whether or not the skip happens.
// - Increment-skip leaves the result register and carry flag alone.
// - Opcode 4 writes the call's own address plus one to the effective address.
// - The call then loads the instruction pointer with the effective address plus one.
// - Otherwise the instruction pointer advances by one per instruction.
// - Page bit clear selects page zero, set selects the instruction's own page.
// - Indirect bit set reads the formed address and uses that word as effective address.
module msj_exec (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [11:0] instr,
  input wire logic [11:0] instr_addr,
  input wire logic load_en,
  input wire logic [11:0] load_result,
  input wire logic load_carry,
  input wire logic mem_load_en,
  input wire logic [11:0] mem_load_addr,
  input wire logic [11:0] mem_load_data,
  output logic busy,
  output logic done,
  output logic [11:0] next_instruction_pointer,
  output logic [11:0] result_register,
  output logic carry_flag,
  output logic skip_taken,
  output logic [11:0] mem_peek
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  // Pulls the three-bit operation code out of an instruction word.
  function automatic logic [2:0] opcode_of(input logic [11:0] word);
    return word[msj_pkg::OPC_HI:msj_pkg::OPC_LO];
  endfunction

  // Direct address inside page zero or inside the page that holds the instruction.
  function automatic logic [11:0] form_addr(input logic [11:0] word, input logic [11:0] where);
    logic [11:0] addr;
    addr = {5'h00, word[msj_pkg::OFS_HI:0]};
    if (word[msj_pkg::PAGE_BIT]) begin
      addr = {where[msj_pkg::PAGE_HI:msj_pkg::PAGE_LO], word[msj_pkg::OFS_HI:0]};
    end
    return addr;
  endfunction

  // State that follows once the effective address is settled.
  function automatic msj_pkg::msj_state_type after_address(input logic [2:0] op);
    msj_pkg::msj_state_type nxt;
    case (op)
      msj_pkg::OPC_INC_SKIP: nxt = msj_pkg::MSJ_READ;
      msj_pkg::OPC_STORE_CLEAR: nxt = msj_pkg::MSJ_WRITE;
      msj_pkg::OPC_CALL: nxt = msj_pkg::MSJ_WRITE;
      msj_pkg::OPC_JUMP: nxt = msj_pkg::MSJ_DONE;
      default: nxt = msj_pkg::MSJ_DONE;
    endcase
    return nxt;
  endfunction

  // Word that a store or a call leaves in memory; an increment overwrites it later.
  function automatic logic [11:0] write_value(input logic [2:0] op, input logic [11:0] where,
    input logic [11:0] result);
    logic [11:0] value;
    value = result;
    if (op == msj_pkg::OPC_CALL) begin
      value = where + msj_pkg::WORD_ONE;
    end
    return value;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  msj_pkg::msj_state_type state_q;
  msj_pkg::msj_state_type state_d;
  logic phase_q;
  logic phase_d;
  logic [11:0] instr_q;
  logic [11:0] instr_d;
  logic [11:0] iaddr_q;
  logic [11:0] iaddr_d;
  logic [11:0] ea_q;
  logic [11:0] ea_d;
  logic [11:0] data_q;
  logic [11:0] data_d;
  logic [11:0] ptr_q;
  logic [11:0] ptr_d;
  logic [11:0] result_q;
  logic [11:0] result_d;
  logic carry_q;
  logic carry_d;
  logic skip_q;
  logic skip_d;
  logic done_q;
  logic done_d;
  logic busy_q;
  logic busy_d;
  logic [2:0] op_cur;
  logic mem_we;
  logic [11:0] mem_addr;
  logic [11:0] mem_wdata;
  logic [11:0] mem_rdata;

  assign op_cur = opcode_of(instr_q);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Indirect operands and increments take two cycles each, because the memory
  // registers its read data; phase_q marks the cycle in which that word stands.
  always_comb begin
    state_d = state_q;
    phase_d = 1'b0;
    instr_d = instr_q;
    iaddr_d = iaddr_q;
    ea_d = ea_q;
    data_d = data_q;
    case (state_q)
      msj_pkg::MSJ_IDLE: begin
        if (start) begin
          instr_d = instr;
          iaddr_d = instr_addr;
          ea_d = form_addr(instr, instr_addr);
          data_d = write_value(opcode_of(instr), instr_addr, result_q);
          if (instr[msj_pkg::IND_BIT]) begin
            state_d = msj_pkg::MSJ_DEFER;
          end else begin
            state_d = after_address(opcode_of(instr));
          end
        end
      end
      msj_pkg::MSJ_DEFER: begin
        phase_d = ~phase_q;
        if (phase_q) begin
          ea_d = mem_rdata;
          state_d = after_address(op_cur);
        end
      end
      msj_pkg::MSJ_READ: begin
        phase_d = ~phase_q;
        if (phase_q) begin
          data_d = mem_rdata + msj_pkg::WORD_ONE;
          state_d = msj_pkg::MSJ_WRITE;
        end
      end
      msj_pkg::MSJ_WRITE: begin
        state_d = msj_pkg::MSJ_DONE;
      end
      msj_pkg::MSJ_DONE: begin
        state_d = msj_pkg::MSJ_IDLE;
      end
      default: begin
        state_d = msj_pkg::MSJ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= msj_pkg::MSJ_IDLE;
      phase_q <= 1'b0;
      instr_q <= msj_pkg::WORD_ZERO;
      iaddr_q <= msj_pkg::WORD_ZERO;
      ea_q <= msj_pkg::WORD_ZERO;
      data_q <= msj_pkg::WORD_ZERO;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      instr_q <= instr_d;
      iaddr_q <= iaddr_d;
      ea_q <= ea_d;
      data_q <= data_d;
    end
  end

  // ----------------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------------
  // Only the load port writes the carry flag, so none of these instructions can disturb it.
  always_comb begin
    ptr_d = ptr_q;
    result_d = result_q;
    carry_d = carry_q;
    skip_d = skip_q;
    done_d = done_q;
    busy_d = (state_d != msj_pkg::MSJ_IDLE);
    if (state_q == msj_pkg::MSJ_IDLE) begin
      if (load_en) begin
        result_d = load_result;
        carry_d = load_carry;
      end
      // Done and skip stand until the next instruction is taken, so a slow caller cannot miss them.
      if (start) begin
        done_d = 1'b0;
        skip_d = 1'b0;
      end
    end
    if (state_q == msj_pkg::MSJ_DONE) begin
      done_d = 1'b1;
      ptr_d = iaddr_q + msj_pkg::WORD_ONE;
      case (op_cur)
        msj_pkg::OPC_STORE_CLEAR: begin
          result_d = msj_pkg::WORD_ZERO;
        end
        msj_pkg::OPC_JUMP: begin
          ptr_d = ea_q;
        end
        msj_pkg::OPC_INC_SKIP: begin
          if (data_q == msj_pkg::WORD_ZERO) begin
            skip_d = 1'b1;
            ptr_d = iaddr_q + msj_pkg::WORD_ONE + msj_pkg::WORD_ONE;
          end
        end
        msj_pkg::OPC_CALL: begin
          ptr_d = ea_q + msj_pkg::WORD_ONE;
        end
        default: begin
          ptr_d = iaddr_q + msj_pkg::WORD_ONE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_q <= msj_pkg::PTR_RESET;
      result_q <= msj_pkg::RES_RESET;
      carry_q <= msj_pkg::CARRY_RESET;
      skip_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      result_q <= result_d;
      carry_q <= carry_d;
      skip_q <= skip_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------------
  // While idle the load side owns the memory, so the caller can preload and inspect words.
  always_comb begin
    mem_we = 1'b0;
    mem_addr = ea_q;
    mem_wdata = data_q;
    case (state_q)
      msj_pkg::MSJ_IDLE: begin
        mem_we = mem_load_en;
        mem_addr = mem_load_addr;
        mem_wdata = mem_load_data;
      end
      msj_pkg::MSJ_WRITE: begin
        mem_we = 1'b1;
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  msj_mem i_mem (
    .ref_clk(ref_clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  assign busy = busy_q;
  assign done = done_q;
  assign next_instruction_pointer = ptr_q;
  assign result_register = result_q;
  assign carry_flag = carry_q;
  assign skip_taken = skip_q;
  assign mem_peek = mem_rdata;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_store_data: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == msj_pkg::MSJ_WRITE && op_cur == msj_pkg::OPC_STORE_CLEAR) |-> (mem_wdata == result_q)
  ) else $error("store writes a word other than the result register");

  a_store_clears: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == msj_pkg::MSJ_DONE && op_cur == msj_pkg::OPC_STORE_CLEAR) |=> (result_q == msj_pkg::WORD_ZERO)
  ) else $error("result register not zero after store");

  a_jump_target: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == msj_pkg::MSJ_DONE && op_cur == msj_pkg::OPC_JUMP) |=> (ptr_q == $past(ea_q))
  ) else $error("jump did not load the effective address");

  a_carry_held: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q != msj_pkg::MSJ_IDLE) |=> $stable(carry_q)
  ) else $error("carry flag changed during execution");

  a_result_held: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q != msj_pkg::MSJ_IDLE && op_cur != msj_pkg::OPC_STORE_CLEAR) |=> $stable(result_q)
  ) else $error("result register changed during execution");

  a_incr_writeback: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == msj_pkg::MSJ_WRITE && op_cur == msj_pkg::OPC_INC_SKIP) |->
      (mem_we && mem_wdata == $past(mem_rdata) + msj_pkg::WORD_ONE)
  ) else $error("increment did not write back the word plus one");

  a_skip_step: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == msj_pkg::MSJ_DONE && op_cur == msj_pkg::OPC_INC_SKIP && data_q == msj_pkg::WORD_ZERO) |=>
      (ptr_q == $past(iaddr_q) + msj_pkg::WORD_ONE + msj_pkg::WORD_ONE)
  ) else $error("zero increment did not skip one word");

  a_call_return: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == msj_pkg::MSJ_DONE && op_cur == msj_pkg::OPC_CALL) |=> (ptr_q == $past(ea_q) + msj_pkg::WORD_ONE)
  ) else $error("call did not continue at the second word");
endmodule

/* dv/msj_mem_model.sv */
// Memory-side partner that loads and selects words.
module msj_mem_model (
  input wire logic ref_clk,
  output logic en = 1'b0,
  output logic [11:0] addr = 12'h000,
  output logic [11:0] data = 12'h000
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic put(input logic [11:0] a, input logic [11:0] d, input logic e);
    @(posedge ref_clk) {en, addr, data} <= {e, a, d};
    @(posedge ref_clk) en <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

/* dv/msj_exec_tb_top.sv */
// Self-checking bench for the memory-operand instruction executor.
module msj_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst = 1'b1, go = 1'b0, ld = 1'b0, me, bz, dn, cy, sk;
  logic [11:0] ir = 12'h000, ia = 12'h000, ma, md, pc, ac, pk;
  int mismatches = 0, cmp_count = 0;
  initial forever #5 ref_clk = ~ref_clk;
  msj_mem_model i_mem (.ref_clk(ref_clk), .en(me), .addr(ma), .data(md));
  msj_exec i_dut (.ref_clk(ref_clk), .rst(rst), .start(go), .instr(ir), .instr_addr(ia), .load_en(ld),
    .load_result(12'h29c), .load_carry(1'b1), .mem_load_en(me), .mem_load_addr(ma), .mem_load_data(md),
    .busy(bz), .done(dn), .next_instruction_pointer(pc), .result_register(ac), .carry_flag(cy),
    .skip_taken(sk), .mem_peek(pk));
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("[FAIL] %s exp %h got %h", n, e, s);
      mismatches++;
    end
  endtask
  // Runs one instruction, checks pointer, result, carry, then the word at ea.
  task automatic run(input logic [11:0] i, a, p, r, ea, w);
    @(posedge ref_clk) {ir, ia, go} <= {i, a, 1'b1};
    @(posedge ref_clk) go <= 1'b0;
    repeat (50) begin
      @(posedge ref_clk);
      if (dn === 1'b1) break;
    end
    #1 chk("done", 12'h001, {11'h0, dn});
    chk("ptr", p, pc);
    chk("res", r, ac);
    chk("carry", 12'h001, {11'h0, cy});
    i_mem.put(ea, 12'h000, 1'b0);
    chk("word", w, pk);
  endtask
  task automatic report_and_stop();
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk) ld <= 1'b1;
    @(posedge ref_clk) ld <= 1'b0;
    i_mem.put(12'h095, 12'hfac, 1'b1);
    run(12'h695, 12'h080, 12'h081, 12'h000, 12'h095, 12'h29c);
    i_mem.put(12'h0a8, 12'hfff, 1'b1);
    run(12'h4a8, 12'h081, 12'h083, 12'h000, 12'h0a8, 12'h000);
    run(12'hac0, 12'h0a8, 12'h0c0, 12'h000, 12'h0a8, 12'h000);
    run(12'h8e8, 12'h080, 12'h0e9, 12'h000, 12'h0e8, 12'h081);
    i_mem.put(12'h050, 12'h3c0, 1'b1);
    run(12'hb50, 12'h0e9, 12'h3c0, 12'h000, 12'h050, 12'h3c0);
    report_and_stop();
  end
  initial begin
    #20000 mismatches++;
    report_and_stop();
  end
endmodule
